// ---- board_glue_pkg.sv ----
package board_glue_pkg;
    // oscillator rate and processor clock division
    localparam int unsigned CLOCK_MHZ = 125;
    localparam int unsigned CLOCK_DIVIDE = 4;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam logic [1:0] DIV_FIRST = 2'h0;
    // restart pulse length in ns, rounded up to whole cycles
    localparam int unsigned RESTART_TIME_NS = 2000;
    localparam int unsigned RESTART_CYCLES = (RESTART_TIME_NS * CLOCK_MHZ + 999) / 1000;
    // a valid reset is low for more than this many processor clock periods
    localparam int unsigned MIN_RESET_PERIODS = 8;
    localparam int unsigned MIN_LOW_CYCLES = (MIN_RESET_PERIODS + 1) * CLOCK_DIVIDE;
    // upper address field examined by the decoder
    localparam int unsigned DECODE_MSB = 15;
    localparam int unsigned DECODE_LSB = 10;
    localparam int unsigned DECODE_W = DECODE_MSB - DECODE_LSB + 1;
    // decode patterns on address bits 15..10
    localparam logic [5:0] IO_GROUP_FIELD = 6'h39;
    // socket window sits on bits 15..12; field bit 1 (address bit 11) picks the socket
    localparam logic [3:0] SOCKET_LOW_FIELD = 4'hc;
    localparam logic [3:0] SOCKET_HIGH_FIELD = 4'hf;
    localparam int unsigned SOCKET_PICK_BIT = 1;

    typedef struct packed {
        logic io_group;
        logic socket_one;
        logic socket_two;
    } select_t;

    localparam select_t SELECT_NONE = 3'h0;

    typedef enum logic [0:0] {
        RESTART_ACTIVE = 1'b0,
        RESTART_IDLE = 1'b1
    } restart_state_t;
endpackage

// ---- board_reset_and_address_decode.sv ----
`timescale 1ns/1ps
module board_reset_and_address_decode
    import board_glue_pkg::*;
#(
    parameter int unsigned RESTART_LEN = RESTART_CYCLES,
    parameter int unsigned COUNT_W = 10,
    parameter bit SOCKETS_HIGH = 1'b0
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic bus_reset_n_in,
    input wire logic [15:0] address_in,
    input wire logic valid_address_in,
    output logic processor_reset_n_out,
    output logic parallel_interface_adapter_reset_n_out,
    output logic programmable_timer_module_reset_n_out,
    output logic processor_phase_one_out,
    output logic processor_phase_two_out,
    output logic system_phase_two_out,
    output logic parallel_interface_adapter_select_out,
    output logic program_socket_one_select_out,
    output logic program_socket_two_select_out
);
    // counters must hold both the pulse and the validity window
    if (RESTART_LEN < MIN_LOW_CYCLES || RESTART_LEN >= (1 << COUNT_W)) begin : g_bad_restart
        $error("restart length does not fit the counter or is too short");
    end

    localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;
    localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);
    localparam logic [COUNT_W-1:0] RESTART_END = COUNT_W'(RESTART_LEN - 1);
    localparam logic [COUNT_W-1:0] LOW_END = COUNT_W'(MIN_LOW_CYCLES - 1);

    // bus reset is a pin: two flops before anything looks at it
    logic bus_sync_a;
    logic bus_sync_b;
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_sync_a <= 1'b1;
            bus_sync_b <= 1'b1;
        end else begin
            bus_sync_a <= bus_reset_n_in;
            bus_sync_b <= bus_sync_a;
        end
    end

    // restart one-shot and bus reset qualifier
    restart_state_t state;
    restart_state_t next_state;
    logic [COUNT_W-1:0] pulse_count;
    logic [COUNT_W-1:0] next_pulse_count;
    logic [COUNT_W-1:0] low_count;
    logic [COUNT_W-1:0] next_low_count;
    logic reset_n;
    logic next_reset_n;

    always_comb begin
        next_state = state;
        next_pulse_count = pulse_count;
        next_low_count = COUNT_ZERO;
        next_reset_n = 1'b1;
        unique case (state)
            RESTART_ACTIVE: begin
                next_reset_n = 1'b0;
                // a bus reset still held keeps the pulse from timing out
                if (!bus_sync_b) begin
                    next_pulse_count = COUNT_ZERO;
                end else if (pulse_count == RESTART_END) begin
                    next_state = RESTART_IDLE;
                    next_reset_n = 1'b1;
                end else begin
                    next_pulse_count = pulse_count + COUNT_ONE;
                end
            end
            RESTART_IDLE: begin
                // glitches shorter than the window never reach the parts
                if (!bus_sync_b) begin
                    next_low_count = low_count + COUNT_ONE;
                    if (low_count == LOW_END) begin
                        next_state = RESTART_ACTIVE;
                        next_pulse_count = COUNT_ZERO;
                        next_low_count = COUNT_ZERO;
                        next_reset_n = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= RESTART_ACTIVE;
            pulse_count <= COUNT_ZERO;
            low_count <= COUNT_ZERO;
            reset_n <= 1'b0;
        end else begin
            state <= next_state;
            pulse_count <= next_pulse_count;
            low_count <= next_low_count;
            reset_n <= next_reset_n;
        end
    end

    // one reset line fans out so every part starts cleared together
    assign processor_reset_n_out = reset_n;
    assign parallel_interface_adapter_reset_n_out = reset_n;
    assign programmable_timer_module_reset_n_out = reset_n;

    // divide by four; phases never overlap since each is one half of the count
    logic [1:0] div;
    logic [1:0] next_div;
    logic phase_one;
    logic phase_two;
    logic next_phase_one;
    logic next_phase_two;

    always_comb begin
        next_div = (div == DIV_LAST) ? DIV_FIRST : div + 2'h1;
        next_phase_one = ~next_div[1];
        next_phase_two = next_div[1];
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div <= DIV_FIRST;
            phase_one <= 1'b1;
            phase_two <= 1'b0;
        end else begin
            div <= next_div;
            phase_one <= next_phase_one;
            phase_two <= next_phase_two;
        end
    end

    assign processor_phase_one_out = phase_one;
    assign processor_phase_two_out = phase_two;
    // the timers take this as their internal 31.25 MHz count source
    assign system_phase_two_out = phase_two;

    // address decode on the upper field only; low bits are ignored on purpose
    logic [DECODE_W-1:0] field;
    logic socket_hit;
    select_t select;
    select_t next_select;

    always_comb begin
        field = address_in[DECODE_MSB:DECODE_LSB];
        socket_hit = SOCKETS_HIGH ? (field[DECODE_W-1:SOCKET_PICK_BIT+1] == SOCKET_HIGH_FIELD)
                                  : (field[DECODE_W-1:SOCKET_PICK_BIT+1] == SOCKET_LOW_FIELD);
        next_select = SELECT_NONE;
        if (valid_address_in) begin
            // whole 1K block goes to the adapter and timer group
            next_select.io_group = (field == IO_GROUP_FIELD);
            next_select.socket_one = socket_hit && !field[SOCKET_PICK_BIT];
            next_select.socket_two = socket_hit && field[SOCKET_PICK_BIT];
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            select <= SELECT_NONE;
        end else begin
            select <= next_select;
        end
    end

    // selects are registered and clear to none while resetn_in is low so the parts see clean lines
    assign parallel_interface_adapter_select_out = select.io_group;
    assign program_socket_one_select_out = select.socket_one;
    assign program_socket_two_select_out = select.socket_two;

    // the timer modes live in the timer part; the board only presets it via reset

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_restart_len_hold: assert property (
        $rose(state == RESTART_ACTIVE) |-> !processor_reset_n_out [*8])
        else $error("restart pulse ended too soon");
    a_short_low_ignored: assert property (
        (state == RESTART_IDLE && !bus_sync_b && low_count < LOW_END)
        |=> processor_reset_n_out)
        else $error("short bus reset started a restart");
    a_long_low_taken: assert property (
        (state == RESTART_IDLE && low_count == LOW_END && !bus_sync_b)
        |=> !processor_reset_n_out)
        else $error("valid bus reset not taken");
    a_resets_agree: assert property (
        parallel_interface_adapter_reset_n_out == processor_reset_n_out &&
        programmable_timer_module_reset_n_out == processor_reset_n_out)
        else $error("reset lines disagree");
    a_divide_four: assert property (
        $rose(processor_phase_two_out) |-> ##1 processor_phase_two_out ##1
        !processor_phase_two_out ##1 !processor_phase_two_out ##1 processor_phase_two_out)
        else $error("phase two not divided by four");
    a_phases_apart: assert property (
        processor_phase_one_out != processor_phase_two_out)
        else $error("phases overlap");
    a_one_select: assert property (
        $onehot0({select.io_group, select.socket_one, select.socket_two}))
        else $error("more than one select");
    a_io_window: assert property (
        valid_address_in && address_in[15:10] == 6'h39 |=> select.io_group)
        else $error("io group not selected");
    a_internal_quiet: assert property (
        address_in[15:7] == 9'h000 |=> select == SELECT_NONE)
        else $error("select on internal memory");
    a_socket_window: assert property (
        select.socket_one || select.socket_two |->
        $past(address_in[15:12]) == (SOCKETS_HIGH ? 4'hf : 4'hc))
        else $error("socket selected outside its window");

    c_bus_restart: cover property (state == RESTART_IDLE ##1 state == RESTART_ACTIVE);
    c_socket_two: cover property (select.socket_two);
    c_io_access: cover property (select.io_group);
    c_power_up_done: cover property ($rose(processor_reset_n_out));
endmodule

// ---- bus_reset_source.sv ----
`timescale 1ns/1ps
// far side of the board: a bus module that may pull the shared reset line
module bus_reset_source (
    input wire logic clock_in,
    output logic bus_reset_n_out
);
    // line has a pull-up on the bus, so released means high
    initial begin
        bus_reset_n_out = 1'b1;
    end

    // hold the line low for a whole number of cycles, then let go
    task automatic drive_low(input int cycles);
        @(posedge clock_in);
        bus_reset_n_out <= 1'b0;
        repeat (cycles) @(posedge clock_in);
        bus_reset_n_out <= 1'b1;
    endtask
endmodule

// ---- board_reset_and_address_decode_tb_top.sv ----
`timescale 1ns/1ps
module board_reset_and_address_decode_tb_top;
    import board_glue_pkg::*;
    // short restart keeps the run brief; must not fall below the bus low threshold
    localparam int unsigned RL = 40;
    logic clock_in;
    logic resetn_in;
    logic bus_reset_n;
    logic [15:0] address_in;
    logic valid_address_in;
    logic [2:0] rst_n;
    logic p1, p2, sys2;
    select_t sel_lo, sel_hi;
    int mismatches = 0;
    int n_compared = 0;

    board_reset_and_address_decode #(.RESTART_LEN(RL)) board_reset_and_address_decode_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .bus_reset_n_in(bus_reset_n),
        .address_in(address_in), .valid_address_in(valid_address_in),
        .processor_reset_n_out(rst_n[2]), .parallel_interface_adapter_reset_n_out(rst_n[1]),
        .programmable_timer_module_reset_n_out(rst_n[0]),
        .processor_phase_one_out(p1), .processor_phase_two_out(p2), .system_phase_two_out(sys2),
        .parallel_interface_adapter_select_out(sel_lo.io_group),
        .program_socket_one_select_out(sel_lo.socket_one),
        .program_socket_two_select_out(sel_lo.socket_two));
    // second strap: sockets in the top window, same stimulus
    board_reset_and_address_decode #(.RESTART_LEN(RL), .SOCKETS_HIGH(1'b1))
        board_reset_and_address_decode_high_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .bus_reset_n_in(bus_reset_n),
        .address_in(address_in), .valid_address_in(valid_address_in),
        .processor_reset_n_out(), .parallel_interface_adapter_reset_n_out(),
        .programmable_timer_module_reset_n_out(),
        .processor_phase_one_out(), .processor_phase_two_out(), .system_phase_two_out(),
        .parallel_interface_adapter_select_out(sel_hi.io_group),
        .program_socket_one_select_out(sel_hi.socket_one),
        .program_socket_two_select_out(sel_hi.socket_two));
    bus_reset_source bus_reset_source_inst (.clock_in(clock_in), .bus_reset_n_out(bus_reset_n));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic check(input logic [2:0] got, input logic [2:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // restart after power-up: low for the restart span, then high
    task automatic power_on_restart();
        repeat (RL - 1) @(posedge clock_in);
        #1 check(rst_n, 3'h0, "reset early");
        @(posedge clock_in);
        #1 check(rst_n, 3'h7, "reset late");
    endtask

    // phase two is 2 high 2 low, phase one its inverse, system copy equal
    task automatic clock_phases();
        logic [7:0] h;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_in);
            #1 h[i] = p2;
            check({p1, sys2, 1'b0}, {~p2, p2, 1'b0}, "phase pair");
        end
        for (int i = 4; i < 8; i++)
            check({h[i], h[i - 2]}, {h[i - 4], ~h[i]}, "phase period");
    endtask

    // decode table: low strap and high strap expectations side by side
    task automatic decode_table();
        logic [15:0] a [18] = '{16'h0000, 16'h007F, 16'hE400, 16'hE7FF, 16'hE410, 16'hE3FF,
            16'hE800, 16'hC000, 16'hC7FF, 16'hC800, 16'hCFFF, 16'hD000, 16'hF000, 16'hF7FF,
            16'hF800, 16'hFFFF, 16'h0400, 16'hE400};
        logic [2:0] lo [18] = '{0, 0, 4, 4, 4, 0, 0, 2, 2, 1, 1, 0, 0, 0, 0, 0, 0, 0};
        logic [2:0] hi [18] = '{0, 0, 4, 4, 4, 0, 0, 0, 0, 0, 0, 0, 2, 2, 1, 1, 0, 0};
        for (int i = 0; i < 18; i++) begin
            @(posedge clock_in);
            address_in <= a[i];
            valid_address_in <= (i != 17); // last entry: no valid cycle, no select
            @(posedge clock_in);
            #1 check(sel_lo, lo[i], "low strap");
            check(sel_hi, hi[i], "high strap");
        end
    endtask

    // bus reset: short pulse ignored, long pulse restarts the board
    task automatic bus_reset();
        fork
            // longest low that must still be ignored
            bus_reset_source_inst.drive_low(MIN_LOW_CYCLES - 1);
            for (int i = 0; i < 40; i++) begin
                @(posedge clock_in);
                #1 check(rst_n, 3'h7, "short pulse");
            end
        join
        fork
            bus_reset_source_inst.drive_low(50);
            begin
                // two sync flops plus the validity window before the fall
                repeat (MIN_LOW_CYCLES + 2) @(posedge clock_in);
                #1 check(rst_n, 3'h7, "long pulse early");
                @(posedge clock_in);
                #1 check(rst_n, 3'h0, "long pulse");
            end
        join
        // pin released now; two sync edges then the full restart span
        repeat (RL + 1) @(posedge clock_in);
        #1 check(rst_n, 3'h0, "bus restart hold");
        @(posedge clock_in);
        #1 check(rst_n, 3'h7, "bus restart end");
    endtask

    // watchdog: all scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        mismatches++;
        finish_test();
    end

    initial begin
        resetn_in = 1'b0;
        address_in = 16'h0000;
        valid_address_in = 1'b0;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        power_on_restart();
        clock_phases();
        decode_table();
        bus_reset();
        finish_test();
    end
endmodule
